//--- hdl/crs_device.sv
/*
 crs_device: processor-side pin logic for reset entry, management
 interrupt and strobe, sleep handshake and replacement monitor.
 assumes: core events arrive on clk; link pins are synchronised here;
 configuration bytes are held by software on the cfg_* inputs.
*/
// Behaviour
// - reset aborts all work, enters reset state
// - in reset only hold request is honoured
// - outputs take reset state during reset
// - chipset avoids reset during management mode
// - drive two-bit replacement set index
// - replacement pins float until monitor enabled
// - replacement valid low during line fill
// - management strobe replaces normal strobe in mode
// - management strobe floats during hold
// - management strobe floats until interrupt enabled
// - active-mode bit turns strobe into active flag
// - management interrupt outranks nonmaskable interrupt
// - chipset holds interrupt low two clocks
// - drive interrupt pin low during service
// - interrupt input ignored until enabled
// - active-mode bit makes interrupt pin input-only
// - sleep request drains work, then stops clocks
// - chipset stops clock only while acknowledged
// - restart clock, release request, resume execution
// - sleep request ignored until enabled
// - acknowledge low in sleep or halt low-power
// - acknowledge floats until sleep enabled
`timescale 1ns/1ps
module crs_device
   import crs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   crs_if.dev lnk,
   // configuration bytes
   input wire logic [7:0] cfg_one,
   input wire logic [7:0] cfg_two,
   input wire logic [7:0] cfg_three,
   // core events
   input wire logic bus_cycle,
   input wire logic fill_active,
   input wire logic [1:0] fill_set,
   input wire logic core_busy,
   input wire logic halt_exec,
   input wire logic intr_pending,
   input wire logic nmi_req,
   input wire logic smm_exit,
   // core status
   output logic smi_take,
   output logic nmi_take,
   output logic smm_active,
   output logic core_sleeping,
   output logic in_reset
);
   function automatic logic low_power(input crs_state_e s);
      return (s == CRS_SLEEP) || (s == CRS_HALT_SLEEP);
   endfunction

   logic reset_s;
   logic warm_s;
   logic hold_s;
   logic smi_s;
   logic sleep_req_s;
   logic rst_in;
   logic smi_req;
   logic sleep_req;

   crs_sync2 #(.W(5), .RST_VAL(5'h13)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .din({lnk.cpu_reset, lnk.warm_reset_input, lnk.hold_req, lnk.mgmt_interrupt_n, lnk.sleep_request_n}),
      .dout({reset_s, warm_s, hold_s, smi_s, sleep_req_s})
   );

   crs_state_e state_ff, nxt_state;
   logic [7:0] cfg1_ff, nxt_cfg1;
   logic [7:0] cfg2_ff, nxt_cfg2;
   logic [7:0] cfg3_ff, nxt_cfg3;
   logic [1:0] blank_ff, nxt_blank;
   logic nmi_prev_ff, nxt_nmi_prev;
   logic nmi_pend_ff, nxt_nmi_pend;
   logic smi_take_ff, nxt_smi_take;
   logic nmi_take_ff, nxt_nmi_take;
   logic hold_ack_ff, nxt_hold_ack;
   logic ads_n_ff, nxt_ads_n;
   logic mgmt_address_strobe_n_n_ff, nxt_mgmt_address_strobe_n_n;
   logic mgmt_address_strobe_n_oe_ff, nxt_mgmt_address_strobe_n_oe;
   logic [1:0] rpl_set_ff, nxt_rpl_set;
   logic rpl_val_n_ff, nxt_rpl_val_n;
   logic rpl_oe_ff, nxt_rpl_oe;
   logic ack_n_ff, nxt_ack_n;
   logic ack_oe_ff, nxt_ack_oe;
   logic smi_oe_ff, nxt_smi_oe;
   logic in_reset_ff, nxt_in_reset;

   // warm reset is treated as a reset entry of its own
   assign rst_in = reset_s | warm_s;
   // own trailing drive is blanked so exit does not re-enter
   assign smi_req = cfg1_ff[CFG1_SMI_BIT] & ~smi_s & (blank_ff == 2'h0);
   assign sleep_req = cfg2_ff[CFG2_SLEEP_BIT] & ~sleep_req_s;

   always_comb begin
      nxt_state = state_ff;
      nxt_cfg1 = cfg_one;
      nxt_cfg2 = cfg_two;
      nxt_cfg3 = cfg_three;
      nxt_blank = (blank_ff != 2'h0) ? blank_ff - 2'h1 : 2'h0;
      nxt_nmi_prev = nmi_req;
      // a new edge wins over the take below
      nxt_nmi_pend = nmi_pend_ff | (nmi_req & ~nmi_prev_ff);
      nxt_smi_take = 1'b0;
      nxt_nmi_take = 1'b0;
      case (state_ff)
         CRS_RUN: begin
            if (smi_req) begin
               nxt_state = CRS_SMM;
               nxt_smi_take = 1'b1;
            end else if (nmi_pend_ff) begin
               nxt_nmi_take = 1'b1;
               nxt_nmi_pend = nmi_req & ~nmi_prev_ff;
            end else if (sleep_req) begin
               nxt_state = CRS_DRAIN;
            end else if (halt_exec) begin
               nxt_state = CRS_HALT_SLEEP;
            end
         end
         CRS_DRAIN: begin
            if (!core_busy) begin
               nxt_state = CRS_SLEEP;
            end
         end
         CRS_SLEEP: begin
            if (!sleep_req) begin
               nxt_state = CRS_RUN;
            end
         end
         CRS_HALT_SLEEP: begin
            if (smi_req) begin
               nxt_state = CRS_SMM;
               nxt_smi_take = 1'b1;
            end else if (intr_pending || nmi_pend_ff) begin
               nxt_state = CRS_RUN;
            end
         end
         CRS_SMM: begin
            if (smm_exit) begin
               nxt_state = CRS_RUN;
               nxt_blank = DEV_SMI_BLANK_CYC;
            end
         end
         default: begin
            nxt_state = CRS_RUN;
         end
      endcase
      if (rst_in) begin
         nxt_state = CRS_RUN;
         nxt_cfg1 = CFG_RESET;
         nxt_cfg2 = CFG_RESET;
         nxt_cfg3 = CFG_RESET;
         nxt_blank = 2'h0;
         nxt_nmi_pend = 1'b0;
         nxt_smi_take = 1'b0;
         nxt_nmi_take = 1'b0;
      end
   end

   // pin values
   always_comb begin
      nxt_in_reset = rst_in;
      nxt_hold_ack = hold_s;
      nxt_ads_n = ~(bus_cycle & (state_ff != CRS_SMM)) | rst_in;
      if (cfg3_ff[CFG3_ACTIVE_BIT]) begin
         nxt_mgmt_address_strobe_n_n = ~(nxt_state == CRS_SMM);
      end else begin
         nxt_mgmt_address_strobe_n_n = ~(bus_cycle & (state_ff == CRS_SMM));
      end
      nxt_mgmt_address_strobe_n_oe = cfg1_ff[CFG1_SMI_BIT] & ~hold_s & ~rst_in;
      nxt_rpl_set = fill_active ? fill_set : rpl_set_ff;
      nxt_rpl_val_n = ~fill_active;
      nxt_rpl_oe = cfg1_ff[CFG1_RPL_BIT] & ~rst_in;
      nxt_ack_n = ~low_power(nxt_state);
      nxt_ack_oe = cfg2_ff[CFG2_SLEEP_BIT] & ~rst_in;
      nxt_smi_oe = (nxt_state == CRS_SMM) & cfg1_ff[CFG1_SMI_BIT] & ~cfg3_ff[CFG3_ACTIVE_BIT] & ~rst_in;
      if (rst_in) begin
         nxt_ads_n = PIN_IDLE_N;
         nxt_mgmt_address_strobe_n_n = PIN_IDLE_N;
         nxt_rpl_set = RPL_SET_RESET;
         nxt_rpl_val_n = PIN_IDLE_N;
         nxt_ack_n = PIN_IDLE_N;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= CRS_RUN;
         cfg1_ff <= CFG_RESET;
         cfg2_ff <= CFG_RESET;
         cfg3_ff <= CFG_RESET;
         blank_ff <= 2'h0;
         nmi_prev_ff <= 1'b0;
         nmi_pend_ff <= 1'b0;
         smi_take_ff <= 1'b0;
         nmi_take_ff <= 1'b0;
         hold_ack_ff <= 1'b0;
         ads_n_ff <= PIN_IDLE_N;
         mgmt_address_strobe_n_n_ff <= PIN_IDLE_N;
         mgmt_address_strobe_n_oe_ff <= 1'b0;
         rpl_set_ff <= RPL_SET_RESET;
         rpl_val_n_ff <= PIN_IDLE_N;
         rpl_oe_ff <= 1'b0;
         ack_n_ff <= PIN_IDLE_N;
         ack_oe_ff <= 1'b0;
         smi_oe_ff <= 1'b0;
         in_reset_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         cfg1_ff <= nxt_cfg1;
         cfg2_ff <= nxt_cfg2;
         cfg3_ff <= nxt_cfg3;
         blank_ff <= nxt_blank;
         nmi_prev_ff <= nxt_nmi_prev;
         nmi_pend_ff <= nxt_nmi_pend;
         smi_take_ff <= nxt_smi_take;
         nmi_take_ff <= nxt_nmi_take;
         hold_ack_ff <= nxt_hold_ack;
         ads_n_ff <= nxt_ads_n;
         mgmt_address_strobe_n_n_ff <= nxt_mgmt_address_strobe_n_n;
         mgmt_address_strobe_n_oe_ff <= nxt_mgmt_address_strobe_n_oe;
         rpl_set_ff <= nxt_rpl_set;
         rpl_val_n_ff <= nxt_rpl_val_n;
         rpl_oe_ff <= nxt_rpl_oe;
         ack_n_ff <= nxt_ack_n;
         ack_oe_ff <= nxt_ack_oe;
         smi_oe_ff <= nxt_smi_oe;
         in_reset_ff <= nxt_in_reset;
      end
   end

   // link
   assign lnk.hold_ack = hold_ack_ff;
   assign lnk.normal_address_strobe_n = ads_n_ff;
   assign lnk.mgmt_address_strobe_n_o = mgmt_address_strobe_n_n_ff;
   assign lnk.mgmt_address_strobe_n_oe = mgmt_address_strobe_n_oe_ff;
   assign lnk.replacement_set_index_o = rpl_set_ff;
   assign lnk.replacement_set_index_oe = rpl_oe_ff;
   assign lnk.replacement_valid_n_o = rpl_val_n_ff;
   assign lnk.replacement_valid_n_oe = rpl_oe_ff;
   assign lnk.sleep_ack_n_o = ack_n_ff;
   assign lnk.sleep_ack_n_oe = ack_oe_ff;
   assign lnk.mgmt_interrupt_n_dev_o = 1'b0;
   assign lnk.mgmt_interrupt_n_dev_oe = smi_oe_ff;

   // core status
   assign smi_take = smi_take_ff;
   assign nmi_take = nmi_take_ff;
   assign smm_active = (state_ff == CRS_SMM);
   assign core_sleeping = low_power(state_ff);
   assign in_reset = in_reset_ff;
endmodule

//--- include/crs_pkg.sv
/*
 crs_pkg: shared constants and types for the reset, management-interrupt,
 sleep and replacement-monitor pin logic.
 assumes: one clock of 4 ns period shared by both ends of the link.
*/
package crs_pkg;
   // configuration bit positions
   localparam int CFG1_RPL_BIT = 1;
   localparam int CFG1_SMI_BIT = 2;
   localparam int CFG2_SLEEP_BIT = 3;
   localparam int CFG3_ACTIVE_BIT = 3;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int SMI_MIN_LOW_NS = 4;
   localparam int SMI_MIN_LOW_CYC = (SMI_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;
   // host pulse: margin of one cycle over the least low time
   localparam logic [2:0] HOST_SMI_DRIVE_CYC = 3'(SMI_MIN_LOW_CYC + 1);
   localparam logic [2:0] HOST_SMI_LOAD = 3'(SMI_MIN_LOW_CYC + 1 + SYNC_STAGES);
   localparam logic [2:0] HOST_SMI_TAIL = 3'(SYNC_STAGES);
   // device ignores its own trailing low for this many cycles after exit
   localparam logic [1:0] DEV_SMI_BLANK_CYC = 2'(SYNC_STAGES + 1);

   // reset values of link outputs
   localparam logic PIN_IDLE_N = 1'b1;
   localparam logic [1:0] RPL_SET_RESET = 2'h0;

   typedef enum logic [2:0] {
      CRS_RUN,
      CRS_DRAIN,
      CRS_SLEEP,
      CRS_HALT_SLEEP,
      CRS_SMM
   } crs_state_e;
endpackage

//--- include/crs_if.sv
/*
 crs_if: link between the processor pin logic and the chipset.
 assumes: the bench supplies nothing here; floating lines resolve to
 their pull level (high for active-low pins, zero for the set index).
*/
`timescale 1ns/1ps
interface crs_if;
   // reset and hold
   logic cpu_reset;
   logic warm_reset_input;
   logic hold_req;
   logic hold_ack;
   // management interrupt, open on both sides
   logic mgmt_interrupt_n_dev_o;
   logic mgmt_interrupt_n_dev_oe;
   logic mgmt_interrupt_n_host_o;
   logic mgmt_interrupt_n_host_oe;
   logic mgmt_interrupt_n;
   // strobes
   logic normal_address_strobe_n;
   logic mgmt_address_strobe_n_o;
   logic mgmt_address_strobe_n_oe;
   logic mgmt_address_strobe_n;
   // replacement monitor
   logic [1:0] replacement_set_index_o;
   logic replacement_set_index_oe;
   logic [1:0] replacement_set_index;
   logic replacement_valid_n_o;
   logic replacement_valid_n_oe;
   logic replacement_valid_n;
   // sleep
   logic sleep_request_n;
   logic sleep_ack_n_o;
   logic sleep_ack_n_oe;
   logic sleep_ack_n;

   // pull resolution of the three-state lines (pullup, set index pulls to zero)
   assign mgmt_interrupt_n = (mgmt_interrupt_n_dev_oe ? mgmt_interrupt_n_dev_o : 1'b1)
                           & (mgmt_interrupt_n_host_oe ? mgmt_interrupt_n_host_o : 1'b1);
   assign mgmt_address_strobe_n = mgmt_address_strobe_n_oe ? mgmt_address_strobe_n_o : 1'b1;
   assign replacement_set_index = replacement_set_index_oe ? replacement_set_index_o : 2'h0;
   assign replacement_valid_n = replacement_valid_n_oe ? replacement_valid_n_o : 1'b1;
   assign sleep_ack_n = sleep_ack_n_oe ? sleep_ack_n_o : 1'b1;

   modport dev (
      input cpu_reset, warm_reset_input, hold_req, mgmt_interrupt_n, sleep_request_n,
      output hold_ack, mgmt_interrupt_n_dev_o, mgmt_interrupt_n_dev_oe, normal_address_strobe_n,
      output mgmt_address_strobe_n_o, mgmt_address_strobe_n_oe, replacement_set_index_o,
      output replacement_set_index_oe, replacement_valid_n_o, replacement_valid_n_oe,
      output sleep_ack_n_o, sleep_ack_n_oe
   );
   modport host (
      output cpu_reset, warm_reset_input, hold_req, sleep_request_n,
      output mgmt_interrupt_n_host_o, mgmt_interrupt_n_host_oe,
      input hold_ack, mgmt_interrupt_n, normal_address_strobe_n, mgmt_address_strobe_n,
      input replacement_set_index, replacement_valid_n, sleep_ack_n
   );
endinterface

//--- hdl/crs_sync2.sv
/*
 crs_sync2: two-stage synchroniser for a vector of pin levels.
 assumes: bits are independent levels; no bus coherence is promised.
*/
`timescale 1ns/1ps
module crs_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;
endmodule

//--- hdl/crs_host.sv
/*
 crs_host: chipset-side logic driving reset, hold, management interrupt
 and sleep request, and watching the processor's management strobe.
 assumes: user commands are on clk; link inputs are synchronised here.
*/
`timescale 1ns/1ps
module crs_host
   import crs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   crs_if.host lnk,
   // commands
   input wire logic reset_cmd,
   input wire logic warm_cmd,
   input wire logic hold_cmd,
   input wire logic smi_cmd,
   input wire logic sleep_cmd,
   input wire logic clk_running,
   input wire logic active_mode,
   // status
   output logic smm_seen,
   output logic sleep_acked,
   output logic clk_stop_ok,
   output logic hold_acked,
   output logic fill_seen,
   output logic [1:0] fill_set_seen
);
   logic hold_ack_s;
   logic smi_s;
   logic mgmt_address_strobe_n_s;
   logic ack_s;
   logic replacement_valid_n_s;
   logic [1:0] rplset_s;

   crs_sync2 #(.W(7), .RST_VAL(7'h3c)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .din({lnk.hold_ack, lnk.mgmt_interrupt_n, lnk.mgmt_address_strobe_n, lnk.sleep_ack_n,
            lnk.replacement_valid_n, lnk.replacement_set_index}),
      .dout({hold_ack_s, smi_s, mgmt_address_strobe_n_s, ack_s, replacement_valid_n_s, rplset_s})
   );

   logic cpu_reset_ff, nxt_cpu_reset;
   logic warm_ff, nxt_warm;
   logic hold_ff, nxt_hold;
   logic [2:0] smi_cnt_ff, nxt_smi_cnt;
   logic sleep_req_n_ff, nxt_sleep_req_n;
   logic smm_ff, nxt_smm;

   always_comb begin
      // resets are held off while the handler runs
      nxt_cpu_reset = reset_cmd & ~smm_ff;
      nxt_warm = warm_cmd & ~smm_ff;
      nxt_hold = hold_cmd;
      nxt_smi_cnt = (smi_cnt_ff != 3'h0) ? smi_cnt_ff - 3'h1 : 3'h0;
      if (smi_cmd && (smi_cnt_ff == 3'h0) && !cpu_reset_ff) begin
         nxt_smi_cnt = HOST_SMI_LOAD;
      end
      // trailing cycles cover own drive still in the synchroniser
      if (active_mode) begin
         nxt_smm = ~mgmt_address_strobe_n_s;
      end else begin
         nxt_smm = ~smi_s & (smi_cnt_ff == 3'h0);
      end
      nxt_sleep_req_n = sleep_req_n_ff;
      if (sleep_cmd) begin
         nxt_sleep_req_n = 1'b0;
      end else if (clk_running) begin
         nxt_sleep_req_n = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cpu_reset_ff <= 1'b1;
         warm_ff <= 1'b0;
         hold_ff <= 1'b0;
         smi_cnt_ff <= 3'h0;
         sleep_req_n_ff <= PIN_IDLE_N;
         smm_ff <= 1'b0;
      end else begin
         cpu_reset_ff <= nxt_cpu_reset;
         warm_ff <= nxt_warm;
         hold_ff <= nxt_hold;
         smi_cnt_ff <= nxt_smi_cnt;
         sleep_req_n_ff <= nxt_sleep_req_n;
         smm_ff <= nxt_smm;
      end
   end

   assign lnk.cpu_reset = cpu_reset_ff;
   assign lnk.warm_reset_input = warm_ff;
   assign lnk.hold_req = hold_ff;
   assign lnk.sleep_request_n = sleep_req_n_ff;
   assign lnk.mgmt_interrupt_n_host_o = 1'b0;
   assign lnk.mgmt_interrupt_n_host_oe = (smi_cnt_ff > HOST_SMI_TAIL);

   assign smm_seen = smm_ff;
   assign sleep_acked = ~ack_s;
   assign clk_stop_ok = ~ack_s & ~sleep_req_n_ff;
   assign hold_acked = hold_ack_s;
   assign fill_seen = ~replacement_valid_n_s;
   assign fill_set_seen = rplset_s;
endmodule

//--- tb/crs_assertions.sv
/*
 crs_assertions: concurrent checks on the processor-chipset link.
 assumes: instantiated by the bench beside the link, fed its signals.
*/
`timescale 1ns/1ps
module crs_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   input wire logic cpu_reset,
   input wire logic warm_reset_input,
   input wire logic hold_req,
   input wire logic hold_ack,
   input wire logic mgmt_interrupt_n,
   input wire logic mgmt_interrupt_n_dev_oe,
   input wire logic mgmt_interrupt_n_host_o,
   input wire logic mgmt_interrupt_n_host_oe,
   input wire logic normal_address_strobe_n,
   input wire logic mgmt_address_strobe_n,
   input wire logic mgmt_address_strobe_n_oe,
   input wire logic replacement_set_index_oe,
   input wire logic replacement_valid_n,
   input wire logic sleep_request_n,
   input wire logic sleep_ack_n,
   input wire logic sleep_ack_n_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_hold_follow: assert property (hold_ack == $past(hold_req, 3))
      else $error("hold acknowledge does not trail hold request by three cycles");
   a_reset_floats: assert property ((cpu_reset || warm_reset_input) [*4]
      |-> !mgmt_interrupt_n_dev_oe && !mgmt_address_strobe_n_oe
      && !replacement_set_index_oe && !sleep_ack_n_oe && normal_address_strobe_n)
      else $error("output not in reset state during link reset");
   a_hold_floats: assert property (hold_ack |-> !mgmt_address_strobe_n_oe)
      else $error("management strobe driven during hold");
   a_strobe_excl: assert property (!(!normal_address_strobe_n && !mgmt_address_strobe_n))
      else $error("both address strobes low at once");
   a_smi_needs_line: assert property ($rose(mgmt_interrupt_n_dev_oe) |-> $past(mgmt_interrupt_n, 3) == 1'b0)
      else $error("device drove interrupt pin without a request");
   a_smi_line_low: assert property (mgmt_interrupt_n_dev_oe |-> !mgmt_interrupt_n)
      else $error("interrupt pin not low while device drives it");
   a_host_smi_width: assert property ($rose(mgmt_interrupt_n_host_oe)
      |-> (mgmt_interrupt_n_host_oe && !mgmt_interrupt_n_host_o) [*2])
      else $error("chipset interrupt pulse shorter than two cycles");
   a_ack_release: assert property ($rose(sleep_request_n) && !sleep_ack_n |-> ##[1:5] sleep_ack_n)
      else $error("sleep acknowledge held after request release");

   c_smi_taken: cover property ($rose(mgmt_interrupt_n_dev_oe));
   c_sleep_ack: cover property ($fell(sleep_ack_n));
   c_fill_seen: cover property (!replacement_valid_n);
   c_mgmt_strobe: cover property (!mgmt_address_strobe_n);
endmodule

//--- tb/tb_crs.sv
/*
 tb_crs: self-checking bench joining the processor and chipset pin logic.
 assumes: both ends share one 250 MHz clock; stimulus moves on falling edges.
*/
`timescale 1ns/1ps
module tb_crs;
   import crs_pkg::*;
   logic clk, sys_rst, bus_cycle, fill_active, core_busy, halt_exec, intr_pending, nmi_req, smm_exit;
   logic [7:0] cfg_one, cfg_two, cfg_three, lfsr;
   logic [1:0] fill_set, fill_set_seen;
   logic smi_take, nmi_take, smm_active, core_sleeping, in_reset;
   logic reset_cmd, warm_cmd, hold_cmd, smi_cmd, sleep_cmd, clk_running, active_mode;
   logic smm_seen, sleep_acked, clk_stop_ok, hold_acked, fill_seen;
   int failures, checks, nmi_count;

   crs_if lnk();
   crs_device i_crs_device (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .cfg_one(cfg_one), .cfg_two(cfg_two),
      .cfg_three(cfg_three), .bus_cycle(bus_cycle), .fill_active(fill_active), .fill_set(fill_set),
      .core_busy(core_busy), .halt_exec(halt_exec), .intr_pending(intr_pending), .nmi_req(nmi_req),
      .smm_exit(smm_exit), .smi_take(smi_take), .nmi_take(nmi_take), .smm_active(smm_active),
      .core_sleeping(core_sleeping), .in_reset(in_reset));
   crs_host i_crs_host (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .reset_cmd(reset_cmd), .warm_cmd(warm_cmd),
      .hold_cmd(hold_cmd), .smi_cmd(smi_cmd), .sleep_cmd(sleep_cmd), .clk_running(clk_running),
      .active_mode(active_mode), .smm_seen(smm_seen), .sleep_acked(sleep_acked), .clk_stop_ok(clk_stop_ok),
      .hold_acked(hold_acked), .fill_seen(fill_seen), .fill_set_seen(fill_set_seen));
   crs_assertions i_crs_assertions (.clk(clk), .sys_rst(sys_rst), .cpu_reset(lnk.cpu_reset),
      .warm_reset_input(lnk.warm_reset_input),
      .hold_req(lnk.hold_req), .hold_ack(lnk.hold_ack), .mgmt_interrupt_n(lnk.mgmt_interrupt_n),
      .mgmt_interrupt_n_dev_oe(lnk.mgmt_interrupt_n_dev_oe), .mgmt_interrupt_n_host_o(lnk.mgmt_interrupt_n_host_o),
      .mgmt_interrupt_n_host_oe(lnk.mgmt_interrupt_n_host_oe),
      .normal_address_strobe_n(lnk.normal_address_strobe_n), .mgmt_address_strobe_n(lnk.mgmt_address_strobe_n),
      .mgmt_address_strobe_n_oe(lnk.mgmt_address_strobe_n_oe),
      .replacement_set_index_oe(lnk.replacement_set_index_oe), .replacement_valid_n(lnk.replacement_valid_n),
      .sleep_request_n(lnk.sleep_request_n), .sleep_ack_n(lnk.sleep_ack_n), .sleep_ack_n_oe(lnk.sleep_ack_n_oe));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      if (nmi_take === 1'b1) begin
         nmi_count++;
      end
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // {normal, management} strobe levels one cycle after a bus cycle
   function automatic logic [1:0] exp_strobes(input logic cyc, input logic system_mgmt_mode);
      return !cyc ? 2'h3 : (system_mgmt_mode ? 2'h2 : 2'h1);
   endfunction

   function automatic logic sig(input string n);
      case (n)
         "smi_take": return smi_take;
         "core_sleeping": return core_sleeping;
         "sleep_ack_n": return lnk.sleep_ack_n;
         "in_reset": return in_reset;
         "hold_acked": return hold_acked;
         default: return clk_stop_ok;
      endcase
   endfunction

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // bounded wait; running out ends the run
   task automatic wait_for(input string n, input logic val);
      for (int i = 0; i < 200; i++) begin
         @(negedge clk);
         if (sig(n) === val) begin
            return;
         end
      end
      failures++;
      $display("Error %s expected %h seen %h", n, val, sig(n));
      report_and_stop();
   endtask

   task automatic end_test(input string n);
      $display("%s done checks %0d failures %0d", n, checks, failures);
   endtask

   task automatic pulse_smi();
      smi_cmd = 1'b1;
      @(negedge clk);
      smi_cmd = 1'b0;
   endtask

   initial begin
      {sys_rst, reset_cmd, clk_running} = 3'h7;
      {cfg_one, cfg_two, cfg_three} = '0;
      {bus_cycle, fill_active, core_busy, halt_exec, intr_pending, nmi_req, smm_exit} = '0;
      {warm_cmd, hold_cmd, smi_cmd, sleep_cmd, active_mode} = '0;
      fill_set = 2'h0;
      lfsr = 8'h0c;
      {failures, checks, nmi_count} = '0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      check("in_reset", in_reset, 1'b1);
      reset_cmd = 1'b0;
      wait_for("in_reset", 1'b0);
      check("set_index_oe", lnk.replacement_set_index_oe, 1'b0);
      check("mgmt_strobe_oe", lnk.mgmt_address_strobe_n_oe, 1'b0);
      check("sleep_ack_oe", lnk.sleep_ack_n_oe, 1'b0);
      pulse_smi();
      sleep_cmd = 1'b1;
      repeat (10) @(negedge clk);
      check("smm_active", smm_active, 1'b0);
      check("core_sleeping", core_sleeping, 1'b0);
      sleep_cmd = 1'b0;
      repeat (6) @(negedge clk);
      end_test("refusal");

      cfg_one = 8'h06;
      repeat (3) @(negedge clk);
      check("set_index_oe", lnk.replacement_set_index_oe, 1'b1);
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         fill_set = (i == 0) ? 2'h3 : (i == 1) ? 2'h0 : lfsr[1:0];
         bus_cycle = lfsr[2];
         fill_active = 1'b1;
         @(negedge clk);
         check("valid_n", lnk.replacement_valid_n, 1'b0);
         check("set_index", lnk.replacement_set_index, fill_set);
         check("strobes", {lnk.normal_address_strobe_n, lnk.mgmt_address_strobe_n}, exp_strobes(bus_cycle, 0));
         {fill_active, bus_cycle} = 2'h0;
         @(negedge clk);
         check("valid_n", lnk.replacement_valid_n, 1'b1);
      end
      @(negedge clk);
      check("fill_seen", {fill_seen, fill_set_seen}, {1'b1, fill_set});
      end_test("replacement");

      pulse_smi();
      wait_for("smi_take", 1'b1);
      nmi_req = 1'b1;
      bus_cycle = 1'b1;
      @(negedge clk);
      check("strobes", {lnk.normal_address_strobe_n, lnk.mgmt_address_strobe_n}, exp_strobes(1, 1));
      bus_cycle = 1'b0;
      hold_cmd = 1'b1;
      wait_for("hold_acked", 1'b1);
      check("mgmt_strobe_oe", lnk.mgmt_address_strobe_n_oe, 1'b0);
      hold_cmd = 1'b0;
      wait_for("hold_acked", 1'b0);
      check("nmi_count", nmi_count, 0);
      check("smi_line", lnk.mgmt_interrupt_n, 1'b0);
      warm_cmd = 1'b1;
      repeat (4) @(negedge clk);
      check("warm_held_off", lnk.warm_reset_input, 1'b0);
      check("smm_seen", smm_seen, 1'b1);
      warm_cmd = 1'b0;
      smm_exit = 1'b1;
      @(negedge clk);
      smm_exit = 1'b0;
      repeat (6) @(negedge clk);
      check("smm_active", smm_active, 1'b0);
      check("smi_line", lnk.mgmt_interrupt_n, 1'b1);
      check("nmi_count", nmi_count, 1);
      nmi_req = 1'b0;
      end_test("management");

      cfg_three = 8'h08;
      active_mode = 1'b1;
      repeat (2) @(negedge clk);
      pulse_smi();
      wait_for("smi_take", 1'b1);
      @(negedge clk);
      check("active_flag", lnk.mgmt_address_strobe_n, 1'b0);
      check("smi_dev_oe", lnk.mgmt_interrupt_n_dev_oe, 1'b0);
      smm_exit = 1'b1;
      @(negedge clk);
      smm_exit = 1'b0;
      repeat (4) @(negedge clk);
      check("active_flag", lnk.mgmt_address_strobe_n, 1'b1);
      {cfg_three, active_mode} = '0;
      end_test("active_flag");

      cfg_two = 8'h08;
      core_busy = 1'b1;
      sleep_cmd = 1'b1;
      repeat (8) @(negedge clk);
      check("core_sleeping", core_sleeping, 1'b0);
      check("sleep_ack_n", lnk.sleep_ack_n, 1'b1);
      core_busy = 1'b0;
      wait_for("core_sleeping", 1'b1);
      @(negedge clk);
      check("sleep_ack_n", lnk.sleep_ack_n, 1'b0);
      wait_for("clk_stop_ok", 1'b1);
      check("sleep_acked", sleep_acked, 1'b1);
      {clk_running, sleep_cmd} = 2'h0;
      repeat (6) @(negedge clk);
      check("sleep_request_n", lnk.sleep_request_n, 1'b0);
      clk_running = 1'b1;
      wait_for("core_sleeping", 1'b0);
      wait_for("sleep_ack_n", 1'b1);
      halt_exec = 1'b1;
      @(negedge clk);
      halt_exec = 1'b0;
      wait_for("sleep_ack_n", 1'b0);
      intr_pending = 1'b1;
      wait_for("sleep_ack_n", 1'b1);
      intr_pending = 1'b0;
      end_test("sleep");

      {hold_cmd, warm_cmd} = 2'h3;
      wait_for("in_reset", 1'b1);
      sleep_cmd = 1'b1;
      wait_for("hold_acked", 1'b1);
      repeat (10) @(negedge clk);
      check("core_sleeping", core_sleeping, 1'b0);
      check("set_index_oe", lnk.replacement_set_index_oe, 1'b0);
      end_test("warm_reset");
      report_and_stop();
   end
endmodule
